/* hw/clkpwr_top.sv */
// Purpose: sample clock divider, duty fixer, power modes, overrange and threshold flags
// Assumes: request pin and sysref come from pins and are synchronised; sample, overrange and threshold inputs are not
// Notes:   converter cores run on the divided enable; link carries 4 channels
// ==========================================================
// Notes on behaviour
// R01: divide incoming sample clock by software-chosen 1, 2, 4 or 8.
// R02: host programs the ratio before applying a multiplied clock.
// R03: valid sysref resets the divider to a programmed phase.
// R04: duty fixer can be switched on by software.
// R05: divided clock toward converters has a 50 percent duty cycle; at ratio 1 the code holds it high.
// R06: high request pin asks for low power; default is full power-down.
// R07: power-down by registers too; link stops while powered down.
// R08: standby keeps link running and sends zero for every sample.
// R09: fill select bit 7 sends /K/ characters instead in standby.
// R10: overrange flag per channel, inserted as control bit when count above zero.
// R11: overrange flag delayed exactly like its sample.
// R12: independent threshold monitor and flag pin for each of four channels.
// R13: pin low and no register request means normal operation.
module clkpwr_top #(
    parameter int CHANNELS = 4,
    parameter int SAMPLE_W = 14
) (
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RESETN,
    input  wire logic                  i_low_power_request_pin,
    input  wire logic                  i_sysref,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [15:0]           i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic [CHANNELS*SAMPLE_W-1:0] i_sample,
    input  wire logic [CHANNELS-1:0]   i_over_range,
    input  wire logic [CHANNELS*SAMPLE_W-1:0] i_threshold,
    output logic [7:0]                 o_reg_rdata,
    output logic                       o_conv_clock,
    output logic                       o_conv_enable,
    output logic                       o_duty_cycle_fixer,
    output logic [1:0]                 o_power_mode,
    output logic                       o_link_enable,
    output logic [CHANNELS*18-1:0]     o_link_data,
    output logic [CHANNELS-1:0]        o_threshold_flag
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] pin_sync_ff;
    logic [1:0] nxt_pin_sync;
    logic [1:0] sref_sync_ff;
    logic [1:0] nxt_sref_sync;
    logic       sref_last_ff;
    logic       nxt_sref_last;
    logic       pin_req;
    logic       sref_rise;

    // two-stage capture of the asynchronous pins
    always_comb begin
        nxt_pin_sync  = {pin_sync_ff[0], i_low_power_request_pin};
        nxt_sref_sync = {sref_sync_ff[0], i_sysref};
        nxt_sref_last = sref_sync_ff[1];
    end

    // synchroniser and edge history flops
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_sync_ff  <= 2'h0;
            sref_sync_ff <= 2'h0;
            sref_last_ff <= 1'b0;
        end else begin
            pin_sync_ff  <= nxt_pin_sync;
            sref_sync_ff <= nxt_sref_sync;
            sref_last_ff <= nxt_sref_last;
        end
    end
    assign pin_req   = pin_sync_ff[1];
    assign sref_rise = sref_sync_ff[1] & ~sref_last_ff;

    // ==========================================================
    // register file
    logic [7:0] pwr_a_ff,  nxt_pwr_a;
    logic [7:0] pwr_b_ff,  nxt_pwr_b;
    logic [7:0] div_ff,    nxt_div;
    logic [7:0] duty_ff,   nxt_duty;
    logic [7:0] fill_ff,   nxt_fill;
    logic [7:0] cbits_ff,  nxt_cbits;
    logic [7:0] rdata_ff,  nxt_rdata;
    logic [1:0] mode_ff,   nxt_mode;

    // write decode and read mux; power b bits show live threshold flags
    always_comb begin
        nxt_pwr_a = pwr_a_ff;
        nxt_pwr_b = pwr_b_ff;
        nxt_div   = div_ff;
        nxt_duty  = duty_ff;
        nxt_fill  = fill_ff;
        nxt_cbits = cbits_ff;
        nxt_rdata = rdata_ff;
        if (i_reg_wr) begin
            case (i_reg_addr)
                clkpwr_pkg::OFF_PWR_A:     nxt_pwr_a = i_reg_wdata;   // R07
                clkpwr_pkg::OFF_PWR_B:     nxt_pwr_b = i_reg_wdata;   // R07
                clkpwr_pkg::OFF_DIV_RATIO: nxt_div   = i_reg_wdata;   // R01
                clkpwr_pkg::OFF_DUTY_FIX:  nxt_duty  = i_reg_wdata;   // R04
                clkpwr_pkg::OFF_FILL_SEL:  nxt_fill  = i_reg_wdata;   // R09
                clkpwr_pkg::OFF_CTRL_BITS: nxt_cbits = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                clkpwr_pkg::OFF_PWR_A:     nxt_rdata = {pwr_a_ff[7:2], mode_ff};
                clkpwr_pkg::OFF_PWR_B:     nxt_rdata = {pwr_b_ff[7:4], o_threshold_flag[3:0]};
                clkpwr_pkg::OFF_DIV_RATIO: nxt_rdata = div_ff;
                clkpwr_pkg::OFF_DUTY_FIX:  nxt_rdata = duty_ff;
                clkpwr_pkg::OFF_FILL_SEL:  nxt_rdata = fill_ff;
                clkpwr_pkg::OFF_CTRL_BITS: nxt_rdata = cbits_ff;
                default:                   nxt_rdata = 8'h00;
            endcase
        end
    end

    // control registers and read data
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pwr_a_ff <= clkpwr_pkg::RST_PWR_A;
            pwr_b_ff <= clkpwr_pkg::RST_PWR_B;
            div_ff   <= clkpwr_pkg::RST_DIV_RATIO;
            duty_ff  <= clkpwr_pkg::RST_DUTY_FIX;
            fill_ff  <= clkpwr_pkg::RST_FILL_SEL;
            cbits_ff <= clkpwr_pkg::RST_CTRL_BITS;
            rdata_ff <= 8'h00;
        end else begin
            pwr_a_ff <= nxt_pwr_a;
            pwr_b_ff <= nxt_pwr_b;
            div_ff   <= nxt_div;
            duty_ff  <= nxt_duty;
            fill_ff  <= nxt_fill;
            cbits_ff <= nxt_cbits;
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_reg_rdata = rdata_ff;

    // ==========================================================
    // power mode selection
    logic [1:0] pin_func;
    always_comb begin
        pin_func = pwr_a_ff[clkpwr_pkg::POS_PIN_FUNC +: 2];
        nxt_mode = 2'(clkpwr_pkg::PM_NORMAL);                              // R13
        if (pwr_a_ff[clkpwr_pkg::POS_PWR_MODE +: 2] == 2'(clkpwr_pkg::PM_POWER_DOWN) ||
            pwr_b_ff[clkpwr_pkg::POS_PWR_MODE +: 2] == 2'(clkpwr_pkg::PM_POWER_DOWN)) begin
            nxt_mode = 2'(clkpwr_pkg::PM_POWER_DOWN);                      // R07
        end else if (pin_req && pin_func == 2'h1) begin
            nxt_mode = 2'(clkpwr_pkg::PM_STANDBY);                         // R06
        end else if (pin_req && pin_func == 2'h0) begin
            nxt_mode = 2'(clkpwr_pkg::PM_POWER_DOWN);                      // R06
        end else if (pwr_a_ff[clkpwr_pkg::POS_PWR_MODE +: 2] == 2'(clkpwr_pkg::PM_STANDBY) ||
                     pwr_b_ff[clkpwr_pkg::POS_PWR_MODE +: 2] == 2'(clkpwr_pkg::PM_STANDBY)) begin
            nxt_mode = 2'(clkpwr_pkg::PM_STANDBY);
        end
    end

    // current power mode
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mode_ff <= 2'(clkpwr_pkg::PM_NORMAL);
        end else begin
            mode_ff <= nxt_mode;
        end
    end
    assign o_power_mode = mode_ff;

    // ==========================================================
    // clock divider: toggling output keeps 50 percent duty
    logic [2:0] div_cnt_ff, nxt_div_cnt;
    logic       cclk_ff,    nxt_cclk;
    logic       cen_ff,     nxt_cen;
    logic [2:0] half;
    always_comb begin
        case (div_ff[clkpwr_pkg::POS_DIV_SEL +: 2])                        // R01
            2'h0:    half = 3'h0;
            2'h1:    half = 3'h0;
            2'h2:    half = 3'h1;
            default: half = 3'h3;
        endcase
        nxt_div_cnt = div_cnt_ff;
        nxt_cclk    = cclk_ff;
        nxt_cen     = 1'b0;
        if (mode_ff == 2'(clkpwr_pkg::PM_POWER_DOWN)) begin
            nxt_div_cnt = 3'h0;
            nxt_cclk    = 1'b0;
        end else if (sref_rise && div_ff[clkpwr_pkg::POS_DIV_SYNC_EN]) begin
            nxt_div_cnt = div_ff[clkpwr_pkg::POS_DIV_PHASE +: 3] & half;    // R03
            nxt_cclk    = 1'b0;                                            // R03
        end else if (div_ff[clkpwr_pkg::POS_DIV_SEL +: 2] == 2'h0) begin
            nxt_cen     = 1'b1;                                            // R01
            nxt_cclk    = 1'b1;
        end else if (div_cnt_ff >= half) begin
            nxt_div_cnt = 3'h0;
            nxt_cclk    = ~cclk_ff;                                        // R05
            nxt_cen     = ~cclk_ff;
        end else begin
            nxt_div_cnt = div_cnt_ff + 3'h1;
        end
    end

    // divider count, divided clock and enable
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            div_cnt_ff <= 3'h0;
            cclk_ff    <= 1'b0;
            cen_ff     <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
            cclk_ff    <= nxt_cclk;
            cen_ff     <= nxt_cen;
        end
    end
    assign o_conv_clock  = cclk_ff;
    assign o_conv_enable = cen_ff;

    // duty fixer enable straight from its control bit
    logic dfix_ff, nxt_dfix;
    always_comb nxt_dfix = duty_ff[clkpwr_pkg::POS_DUTY_EN];              // R04
    // fixer enable register
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) dfix_ff <= 1'b0;
        else           dfix_ff <= nxt_dfix;
    end
    assign o_duty_cycle_fixer = dfix_ff;

    // ==========================================================
    // per channel sample path, overrange and threshold flag
    wire  logic [CHANNELS*18-1:0] link_words;
    wire  logic [CHANNELS-1:0]    thr_bits;
    logic                         lnk_en_ff, nxt_lnk_en;

    // link stops only in power-down; standby keeps it running
    always_comb nxt_lnk_en = (mode_ff != 2'(clkpwr_pkg::PM_POWER_DOWN));  // R07 R08
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) lnk_en_ff <= 1'b0;
        else           lnk_en_ff <= nxt_lnk_en;
    end
    assign o_link_enable = lnk_en_ff;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic [SAMPLE_W:0]   pipe_ff  [clkpwr_pkg::PIPE_DEPTH];
            logic [SAMPLE_W:0]   nxt_pipe [clkpwr_pkg::PIPE_DEPTH];
            logic [17:0]         word_ff, nxt_word;
            logic                thr_ff,  nxt_thr;
            logic [SAMPLE_W-1:0] mag;

            // sample and flag share one pipeline so latency matches
            always_comb begin
                for (int i = 0; i < clkpwr_pkg::PIPE_DEPTH; i++) nxt_pipe[i] = pipe_ff[i];
                if (cen_ff) begin
                    nxt_pipe[0] = {i_over_range[ch], i_sample[ch*SAMPLE_W +: SAMPLE_W]};  // R11
                    for (int i = 1; i < clkpwr_pkg::PIPE_DEPTH; i++) nxt_pipe[i] = pipe_ff[i-1];
                end
            end
            // pipeline registers, advanced only by the converter enable
            always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    for (int i = 0; i < clkpwr_pkg::PIPE_DEPTH; i++) pipe_ff[i] <= '0;
                end else begin
                    for (int i = 0; i < clkpwr_pkg::PIPE_DEPTH; i++) pipe_ff[i] <= nxt_pipe[i];
                end
            end

            // link word: sample, overrange control bit, standby fill
            always_comb begin
                mag = pipe_ff[0][SAMPLE_W-1] ? SAMPLE_W'(-pipe_ff[0][SAMPLE_W-1:0])
                                              : pipe_ff[0][SAMPLE_W-1:0];
                nxt_thr  = (mag > i_threshold[ch*SAMPLE_W +: SAMPLE_W]);  // R12
                nxt_word = {1'b0, 1'b0, pipe_ff[clkpwr_pkg::PIPE_DEPTH-1][SAMPLE_W-1:0],
                            (cbits_ff != 8'h00) & pipe_ff[clkpwr_pkg::PIPE_DEPTH-1][SAMPLE_W], 1'b0}; // R10
                if (mode_ff == 2'(clkpwr_pkg::PM_STANDBY)) begin
                    if (fill_ff[clkpwr_pkg::POS_FILL_K])
                        nxt_word = {1'b1, 1'b0, 8'h00, clkpwr_pkg::K_CHAR};                 // R09
                    else
                        nxt_word = 18'h0_0000;                                              // R08
                end else if (mode_ff == 2'(clkpwr_pkg::PM_POWER_DOWN)) begin
                    nxt_word = 18'h0_0000;
                end
            end
            // link word and threshold flag registers
            always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    word_ff <= 18'h0_0000;
                    thr_ff  <= 1'b0;
                end else begin
                    word_ff <= nxt_word;
                    thr_ff  <= nxt_thr;  // R12
                end
            end
            // each channel drives only its own slice of the outputs
            assign link_words[ch*18 +: 18] = word_ff;
            assign thr_bits[ch]            = thr_ff;
        end
    endgenerate
    assign o_link_data      = link_words;
    assign o_threshold_flag = thr_bits;
endmodule // clkpwr_top

/* hw/clkpwr_pkg.sv */
// Purpose: shared constants and types for the sample clock and power mode block
// Assumes: register port is an 16-bit address, 8-bit data write/read strobe port
// Notes:   offsets are those of the register map; field positions chosen locally
package clkpwr_pkg;
    // ==========================================================
    // register offsets
    localparam logic [15:0] OFF_PWR_A      = 16'h003F;
    localparam logic [15:0] OFF_PWR_B      = 16'h0040;
    localparam logic [15:0] OFF_DIV_RATIO  = 16'h0108;
    localparam logic [15:0] OFF_DUTY_FIX   = 16'h011C;
    localparam logic [15:0] OFF_FILL_SEL   = 16'h0571;
    localparam logic [15:0] OFF_CTRL_BITS  = 16'h0572;
    // ==========================================================
    // field positions
    localparam int POS_PWR_MODE    = 0;   // [1:0] in control a
    localparam int POS_PIN_FUNC    = 4;   // [5:4] in control a
    localparam int POS_DIV_SEL     = 0;   // [1:0] ratio code
    localparam int POS_DIV_PHASE   = 4;   // [6:4] sysref phase
    localparam int POS_DIV_SYNC_EN = 7;
    localparam int POS_DUTY_EN     = 0;
    localparam int POS_FILL_K      = 7;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PWR_A     = 8'h00;
    localparam logic [7:0] RST_PWR_B     = 8'h00;
    localparam logic [7:0] RST_DIV_RATIO = 8'h00;
    localparam logic [7:0] RST_DUTY_FIX  = 8'h00;
    localparam logic [7:0] RST_FILL_SEL  = 8'h00;
    localparam logic [7:0] RST_CTRL_BITS = 8'h00;
    localparam logic [7:0] K_CHAR        = 8'hBC;  // /K/ comma character
    localparam int         PIPE_DEPTH    = 4;      // converter sample latency
    // ==========================================================
    // types
    typedef enum logic [1:0] {PM_NORMAL, PM_POWER_DOWN, PM_STANDBY} pmode_type;
    typedef struct packed {
        logic        valid;
        logic        is_k;
        logic [15:0] word;
    } link_word_type;
endpackage

/* verification/clkpwr_props.sv */
// Purpose: concurrent checks on the clock and power mode block ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the top module, watches outputs plus the request pin and write strobe
module clkpwr_props #(
    parameter int CHANNELS = 4
) (
    input wire logic                    I_CLOCK,
    input wire logic                    I_RESETN,
    input wire logic                    i_low_power_request_pin,
    input wire logic                    i_reg_wr,
    input wire logic                    o_conv_clock,
    input wire logic                    o_conv_enable,
    input wire logic                    o_duty_cycle_fixer,
    input wire logic [1:0]              o_power_mode,
    input wire logic                    o_link_enable,
    input wire logic [CHANNELS*18-1:0]  o_link_data
);
    // ==========================================================
    // cycles since reset release, saturating
    logic [2:0] up_ff;
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) up_ff <= 3'h0;
        else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);
    // ==========================================================
    // pin request steps
    sequence pin_rise_s;
        $rose(i_low_power_request_pin) && o_power_mode == 2'h0;
    endsequence
    sequence mode_left_s;
        ##[1:5] o_power_mode != 2'h0;
    endsequence
    // link state follows the power mode
    pd_link_off_a: assert property (o_power_mode == 2'h1 |=> !o_link_enable)
        else $error("link running in power-down");
    stby_link_on_a: assert property (up_ff == 3'h7 && o_power_mode == 2'h2 |=> o_link_enable)
        else $error("link stopped in standby");
    normal_link_on_a: assert property (up_ff == 3'h7 && o_power_mode == 2'h0 |=> o_link_enable)
        else $error("link stopped in normal mode");
    stby_fill_a: assert property (o_power_mode == 2'h2 |=> o_link_data[17:0] == 18'h0_0000
        || o_link_data[17:0] == {1'b1, 9'h000, clkpwr_pkg::K_CHAR}) else $error("standby word");
    pin_mode_a: assert property (pin_rise_s |-> mode_left_s)
        else $error("pin did not leave normal mode");
    // divider output shape and fixer enable hold
    conv_runs_a: assert property (up_ff == 3'h7 && o_power_mode == 2'h0 |-> ##[0:16] o_conv_enable)
        else $error("converter enable missing");
    fall_no_en_a: assert property ($fell(o_conv_clock) |-> !o_conv_enable)
        else $error("enable on falling divided clock");
    fixer_hold_a: assert property (!i_reg_wr && !$past(i_reg_wr) |=> $stable(o_duty_cycle_fixer))
        else $error("fixer changed without write");
endmodule // clkpwr_props
bind clkpwr_top clkpwr_props #(.CHANNELS(CHANNELS)) i_props (.*);

/* verification/frontend_model.sv */
// Purpose: converter front end feeding samples and overrange to the block
// Assumes: one new sample per clock, 12-bit counting value on every channel
// Notes:   overrange on channel 0 only while the bench asks for it
module frontend_model (
    input  wire logic         i_clk,
    input  wire logic         i_flag_req,
    output logic [55:0]       o_sample,
    output logic [3:0]        o_over_range,
    output logic [11:0]       o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // positive counting samples, never near full scale
    initial o_count = 12'h000;
    always @(posedge i_clk) o_count <= o_count + 12'h001;
    assign o_sample     = {4{2'h0, o_count}};
    assign o_over_range = {3'h0, i_flag_req};
endmodule // frontend_model

/* verification/tb_top.sv */
// Purpose: self-checking bench for the clock and power mode block
// Assumes: front-end model supplies samples, bench drives registers and pins
// Notes:   one task per scenario, watchdog cuts a hang short
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic        clk = 1'b0, rst_n = 1'b0, pin = 1'b0, sysref = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, flag = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [55:0] sample, thr = {4{14'h1FFF}};
    logic [3:0]  ovr, tflag;
    logic [11:0] count;
    logic [1:0]  mode;
    logic        cclk, cen, fix, link_en;
    logic [71:0] link;
    int          mismatches = 0, checked = 0;
    always #5 clk = ~clk;
    frontend_model i_fe (.i_clk(clk), .i_flag_req(flag), .o_sample(sample),
        .o_over_range(ovr), .o_count(count));
    clkpwr_top i_dut (.I_CLOCK(clk), .I_RESETN(rst_n), .i_low_power_request_pin(pin),
        .i_sysref(sysref), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_sample(sample), .i_over_range(ovr), .i_threshold(thr),
        .o_reg_rdata(rdata), .o_conv_clock(cclk), .o_conv_enable(cen),
        .o_duty_cycle_fixer(fix), .o_power_mode(mode), .o_link_enable(link_en),
        .o_link_data(link), .o_threshold_flag(tflag));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic test_regs();
        logic [15:0] offs [5];
        offs = '{clkpwr_pkg::OFF_PWR_A, clkpwr_pkg::OFF_PWR_B, clkpwr_pkg::OFF_DIV_RATIO,
                 clkpwr_pkg::OFF_DUTY_FIX, clkpwr_pkg::OFF_FILL_SEL};
        foreach (offs[i]) begin
            rd_reg(offs[i]);
            check(18'(rdata), 18'h0_0000);
        end
        wr_reg(clkpwr_pkg::OFF_DUTY_FIX, 8'h01);
        check(18'(fix), 18'h0_0001);
        wr_reg(16'h0123, 8'hFF);
        rd_reg(16'h0123);
        check(18'(rdata), 18'h0_0000);
        $display("register test done");
    endtask
    task automatic test_divider();
        int n;
        int h;
        for (int code = 0; code < 4; code++) begin
            wr_reg(clkpwr_pkg::OFF_DIV_RATIO, 8'(code));
            repeat (12) @(posedge clk);
            n = 0;
            h = 0;
            repeat (64) begin
                @(posedge clk);
                #1;
                n += int'(cen);
                h += int'(cclk);
            end
            check(18'(n), 18'(64 >> code));
            if (code > 0) check(18'(h), 18'h0_0020);
        end
        $display("divider test done");
    endtask
    task automatic test_sysref();
        int d [3];
        wr_reg(clkpwr_pkg::OFF_DIV_RATIO, 8'h83);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wr_reg(clkpwr_pkg::OFF_DIV_RATIO, 8'hA3); // phase state 2
            repeat (3 + 3 * k) @(posedge clk);
            sysref <= 1'b1;
            d[k] = 0;
            do begin
                @(posedge clk);
                #1;
                d[k]++;
            end while ((d[k] < 4 || cen !== 1'b1) && d[k] < 40);
            check(18'(cen), 18'h0_0001);
            @(posedge clk);
            sysref <= 1'b0;
        end
        check(18'(d[1]), 18'(d[0]));
        check(18'(d[2] + 2), 18'(d[0]));
        $display("sysref test done");
    endtask
    task automatic test_power();
        wr_reg(clkpwr_pkg::OFF_PWR_B, 8'h01);
        check(18'({mode, link_en}), 18'h0_0002);
        wr_reg(clkpwr_pkg::OFF_PWR_B, 8'h00);
        wr_reg(clkpwr_pkg::OFF_PWR_A, 8'h02);
        check(18'({mode, link_en}), 18'h0_0005);
        check(link[17:0], 18'h0_0000);
        wr_reg(clkpwr_pkg::OFF_FILL_SEL, 8'h80);
        check(link[17:0], {1'b1, 9'h000, clkpwr_pkg::K_CHAR});
        wr_reg(clkpwr_pkg::OFF_PWR_A, 8'h00);
        check(18'({mode, link_en}), 18'h0_0001);
        @(posedge clk);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(18'({mode, link_en}), 18'h0_0002);
        @(posedge clk);
        pin <= 1'b0;
        wr_reg(clkpwr_pkg::OFF_FILL_SEL, 8'h00);
        wr_reg(clkpwr_pkg::OFF_PWR_A, 8'h10); // pin now asks for standby
        @(posedge clk);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(18'({mode, link_en}), 18'h0_0005);
        check(link[17:0], 18'h0_0000);
        @(posedge clk);
        pin <= 1'b0;
        wr_reg(clkpwr_pkg::OFF_PWR_A, 8'h00);
        check(18'({mode, link_en}), 18'h0_0001);
        $display("power test done");
    endtask
    task automatic test_flags();
        logic [11:0] tag;
        int          n;
        wr_reg(clkpwr_pkg::OFF_DIV_RATIO, 8'h00);
        wr_reg(clkpwr_pkg::OFF_CTRL_BITS, 8'h01);
        @(posedge clk);
        flag <= 1'b1;
        #1 tag = count;
        @(posedge clk);
        flag <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (link[1] !== 1'b1 && n < 40);
        check(18'(link[1]), 18'h0_0001);
        check(18'(link[15:2]), 18'(tag));
        @(posedge clk);
        thr <= {14'h1FFF, 14'h1FFF, 14'h0000, 14'h1FFF};
        repeat (12) @(posedge clk);
        #1;
        check(18'(tflag), 18'h0_0002);
        $display("flag test done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_divider();
        test_sysref();
        test_power();
        test_flags();
        tally_and_finish();
    end
    initial begin
        #300000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top
